// [hdl/pva_pkg.sv]
// Constants and field layouts for the prioritized vector interrupt arbiter
package pva_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned NUM_SRC = 66;        // Interrupt sources, vectors 1..66
  localparam int unsigned VEC_W = 7;           // Vector number width
  localparam int unsigned PADDR_W = 21;        // Program word address width
  localparam int unsigned DATA_W = 16;         // Register data width
  localparam int unsigned RADDR_W = 5;         // Register address width
  localparam int unsigned LVL_W = 2;           // Level field width
  localparam int unsigned RANK_W = 3;          // Arbitration rank width
  localparam int unsigned NUM_RANK = 4;        // Ranks: -1, 0, 1, 2
  localparam int unsigned FLD_PER_REG = 8;     // Level fields per register
  localparam int unsigned NUM_LVL_REGS = 9;    // Level registers
  localparam int unsigned VBA_W = 14;          // Vector base width
  localparam int unsigned VBA_SHIFT = 7;       // Vector base to word address
  localparam int unsigned FAH_W = PADDR_W - DATA_W; // Fast handler high bits

  ////////////////////////////////////////////////////////////////////////////
  // Level field codes
  typedef logic [LVL_W-1:0] pva_lvl_t;
  localparam pva_lvl_t LVL_OFF = 2'h0;         // Source disabled
  localparam pva_lvl_t LVL_P0 = 2'h1;          // Level 0
  localparam pva_lvl_t LVL_P1 = 2'h2;          // Level 1
  localparam pva_lvl_t LVL_P2 = 2'h3;          // Level 2

  // Ranks seen by the core mask; rank 1 is level -1
  typedef logic [RANK_W-1:0] pva_rank_t;
  localparam pva_rank_t RANK_NONE = 3'h0;
  localparam pva_rank_t RANK_SWLP = 3'h1;
  localparam pva_rank_t RANK_P2 = 3'h4;

  // Fixed low-priority software source
  localparam int unsigned SWLP_IDX = 65;
  localparam int unsigned SWLP_REG = SWLP_IDX / FLD_PER_REG;
  localparam int unsigned SWLP_FLD = SWLP_IDX % FLD_PER_REG;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (word index on the register port)
  typedef logic [RADDR_W-1:0] pva_ofs_t;
  localparam pva_ofs_t OFS_LVL0 = 5'h00;       // source_level_regs 0..8
  localparam pva_ofs_t OFS_MATCH_A = 5'h09;    // fast_match_slot_a
  localparam pva_ofs_t OFS_MATCH_B = 5'h0A;    // fast_match_slot_b
  localparam pva_ofs_t OFS_FAL_A = 5'h0B;      // fast_handler_addr_low slot a
  localparam pva_ofs_t OFS_FAH_A = 5'h0C;      // fast_handler_addr_high slot a
  localparam pva_ofs_t OFS_FAL_B = 5'h0D;      // fast_handler_addr_low slot b
  localparam pva_ofs_t OFS_FAH_B = 5'h0E;      // fast_handler_addr_high slot b
  localparam pva_ofs_t OFS_VBA = 5'h0F;        // vector_base_reg
  localparam pva_ofs_t OFS_STATUS = 5'h10;     // Arbiter status, read only

  ////////////////////////////////////////////////////////////////////////////
  // Reset values per flash variant
  localparam logic [VBA_W-1:0] VBA_RST_64K = 14'h0000;
  localparam logic [VBA_W-1:0] VBA_RST_48K = 14'h0040;
  localparam logic [PADDR_W-1:0] BOOT_64K = 21'h000000;
  localparam logic [PADDR_W-1:0] BOOT_48K = 21'h002000;
  localparam logic [PADDR_W-1:0] WDOG_OFS = 21'h000002;
  localparam logic [PADDR_W-1:0] TBL_LAST_OFS = 21'h000085;

endpackage : pva_pkg

// [hdl/pva_level_enc.sv]
// Lowest-index priority encoder for one arbitration rank
`timescale 1ns/10ps
module pva_level_enc #(
  parameter int unsigned N = 66,
  parameter int unsigned IW = 7
) (
  input wire logic [N-1:0] req,
  output logic found,
  output logic [IW-1:0] idx
);

  ////////////////////////////////////////////////////////////////////////////
  // Scan downward so the lowest active index is the last one kept
  always_comb
  begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx = IW'(i);
      end
    end
  end

endmodule // pva_level_enc

// [hdl/pva_arbiter.sv]
// Prioritized vector interrupt arbiter with two fast-interrupt slots
//
// Overview of operation
// - Each of 66 sources gets level 0..2 or off; one keeps a fixed level.
// - Within a level the smallest active vector number wins.
// - A request of enough priority is raised with its jump address.
// - Two fast slots each hold a vector number to treat as fast.
// - Fast only when a slot matches and the request is at level 2.
// - Fast request jumps to the slot's high and low handler words.
// - Fast classification is done here, core gets fast address directly.
// - 64 KB variant: table 0x0000..0x0085, boot 0x0000, watchdog 0x0002.
// - 48 KB variant: table 0x2000..0x2085, boot 0x2000, watchdog 0x2002.
// - All produced addresses are 21-bit word addresses.
// - Table entries are two words each, reaching a 21-bit range.
// - Vector base reset value puts the table on the reset addresses.
// - Programmable levels are 0..2; software low source fixed at -1.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module pva_arbiter #(
  parameter bit VARIANT_48K = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [pva_pkg::NUM_SRC-1:0] src_req,
  input wire logic [pva_pkg::RANK_W-1:0] core_mask,
  input wire logic [pva_pkg::RADDR_W-1:0] reg_addr,
  input wire logic [pva_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pva_pkg::DATA_W-1:0] reg_rdata,
  output logic irq_req,
  output logic irq_fast,
  output logic [pva_pkg::VEC_W-1:0] irq_vec,
  output logic [pva_pkg::PADDR_W-1:0] irq_addr,
  output logic [pva_pkg::PADDR_W-1:0] boot_addr,
  output logic [pva_pkg::PADDR_W-1:0] wdog_addr,
  output logic [pva_pkg::PADDR_W-1:0] tbl_base
);
  import pva_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [NUM_LVL_REGS-1:0][DATA_W-1:0] lvl;
    logic [VEC_W-1:0] match_a;
    logic [VEC_W-1:0] match_b;
    logic [DATA_W-1:0] fal_a;
    logic [FAH_W-1:0] fah_a;
    logic [DATA_W-1:0] fal_b;
    logic [FAH_W-1:0] fah_b;
    logic [VBA_W-1:0] vector_base_reg;
    logic [DATA_W-1:0] rdata;
    logic req;
    logic fast;
    pva_rank_t rank;
    logic [VEC_W-1:0] vec;
    logic [PADDR_W-1:0] addr;
    logic [PADDR_W-1:0] boot;
    logic [PADDR_W-1:0] wdog;
  } pva_state_s;

  // Variant-dependent reset image
  localparam logic [VBA_W-1:0] VBA_RST = VARIANT_48K ? VBA_RST_48K : VBA_RST_64K;
  localparam logic [PADDR_W-1:0] BOOT_RST = VARIANT_48K ? BOOT_48K : BOOT_64K;
  localparam pva_state_s ST_RST = '{
    vector_base_reg: VBA_RST,
    boot: BOOT_RST,
    wdog: BOOT_RST + WDOG_OFS,
    default: '0
  };

  pva_state_s st_r;
  pva_state_s st_nxt;
  logic [NUM_RANK-1:0][NUM_SRC-1:0] rank_req;
  logic [NUM_RANK-1:0] rank_found;
  logic [NUM_RANK-1:0][VEC_W-1:0] rank_idx;
  logic win_found;
  pva_rank_t win_rank;
  logic [VEC_W-1:0] win_idx;
  logic [VEC_W-1:0] win_vec;
  logic win_fwd;
  logic hit_a;
  logic hit_b;
  logic [PADDR_W-1:0] base_addr;
  logic [PADDR_W-1:0] norm_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Sort active sources into rank request vectors
  always_comb
  begin
    rank_req = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (i == SWLP_IDX)
      begin
        rank_req[0][i] = src_req[i];
      end
      else
      begin
        case (st_r.lvl[i / FLD_PER_REG][(i % FLD_PER_REG) * LVL_W +: LVL_W])
          LVL_P0: rank_req[1][i] = src_req[i];
          LVL_P1: rank_req[2][i] = src_req[i];
          LVL_P2: rank_req[3][i] = src_req[i];
          default: ; // Disabled source stays out of every rank
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One lowest-vector encoder per rank
  for (genvar r = 0; r < NUM_RANK; r++)
  begin : g_rank
    pva_level_enc #(
      .N(NUM_SRC),
      .IW(VEC_W)
    ) u_enc (
      .req(rank_req[r]),
      .found(rank_found[r]),
      .idx(rank_idx[r])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Highest non-empty rank wins, then the core mask gates it
  always_comb
  begin
    win_found = 1'b0;
    win_rank = RANK_NONE;
    win_idx = '0;
    for (int r = 0; r < NUM_RANK; r++)
    begin
      if (rank_found[r])
      begin
        win_found = 1'b1;
        win_rank = RANK_W'(r + 1);
        win_idx = rank_idx[r];
      end
    end
    win_vec = win_idx + VEC_W'(1);
    win_fwd = win_found && (win_rank > core_mask);
  end

  // Fast slot compare, level 2 only
  assign hit_a = (win_vec == st_r.match_a) && (win_rank == RANK_P2);
  assign hit_b = (win_vec == st_r.match_b) && (win_rank == RANK_P2);

  // Word address of a normal vector: base plus two words per entry
  assign base_addr = {st_r.vector_base_reg, VBA_SHIFT'(0)};
  assign norm_addr = base_addr + PADDR_W'({win_vec, 1'b0});

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register port and arbitration result
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = '0;
    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_MATCH_A: st_nxt.match_a = reg_wdata[VEC_W-1:0];
        OFS_MATCH_B: st_nxt.match_b = reg_wdata[VEC_W-1:0];
        OFS_FAL_A: st_nxt.fal_a = reg_wdata;
        OFS_FAH_A: st_nxt.fah_a = reg_wdata[FAH_W-1:0];
        OFS_FAL_B: st_nxt.fal_b = reg_wdata;
        OFS_FAH_B: st_nxt.fah_b = reg_wdata[FAH_W-1:0];
        OFS_VBA: st_nxt.vector_base_reg = reg_wdata[VBA_W-1:0];
        default:
        begin
          if (reg_addr < RADDR_W'(NUM_LVL_REGS))
          begin
            st_nxt.lvl[reg_addr] = reg_wdata;
          end
        end
      endcase
    end
    // Fixed-level source has no writable field
    st_nxt.lvl[SWLP_REG][SWLP_FLD * LVL_W +: LVL_W] = LVL_OFF;
    // Register reads, data valid the next cycle only
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_MATCH_A: st_nxt.rdata = DATA_W'(st_r.match_a);
        OFS_MATCH_B: st_nxt.rdata = DATA_W'(st_r.match_b);
        OFS_FAL_A: st_nxt.rdata = st_r.fal_a;
        OFS_FAH_A: st_nxt.rdata = DATA_W'(st_r.fah_a);
        OFS_FAL_B: st_nxt.rdata = st_r.fal_b;
        OFS_FAH_B: st_nxt.rdata = DATA_W'(st_r.fah_b);
        OFS_VBA: st_nxt.rdata = DATA_W'(st_r.vector_base_reg);
        OFS_STATUS: st_nxt.rdata = {st_r.req, st_r.fast, st_r.rank, 4'h0, st_r.vec};
        default:
        begin
          if (reg_addr < RADDR_W'(NUM_LVL_REGS))
          begin
            st_nxt.rdata = st_r.lvl[reg_addr];
          end
        end
      endcase
    end
    // Arbitration result toward the core
    st_nxt.req = win_fwd;
    st_nxt.rank = win_fwd ? win_rank : RANK_NONE;
    st_nxt.vec = win_fwd ? win_vec : '0;
    st_nxt.fast = win_fwd && (hit_a || hit_b);
    if (!win_fwd)
    begin
      st_nxt.addr = '0;
    end
    else if (hit_a)
    begin
      st_nxt.addr = {st_r.fah_a, st_r.fal_a};
    end
    else if (hit_b)
    begin
      st_nxt.addr = {st_r.fah_b, st_r.fal_b};
    end
    else
    begin
      st_nxt.addr = norm_addr;
    end
    // Reset entry addresses per variant
    st_nxt.boot = BOOT_RST;
    st_nxt.wdog = BOOT_RST + WDOG_OFS;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = st_r.rdata;
  assign irq_req = st_r.req;
  assign irq_fast = st_r.fast;
  assign irq_vec = st_r.vec;
  assign irq_addr = st_r.addr;
  assign boot_addr = st_r.boot;
  assign wdog_addr = st_r.wdog;
  assign tbl_base = base_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Level register write lands the next cycle
  sequence s_lvl0_wr;
    reg_wr && (reg_addr == OFS_LVL0);
  endsequence

  sequence s_lvl0_rd;
    reg_rd && (reg_addr == OFS_LVL0);
  endsequence

  level_write_a: assert property (
    s_lvl0_wr |=> (st_r.lvl[0] == $past(reg_wdata)))
    else $error("level register write lost");

  level_readback_a: assert property (
    s_lvl0_wr ##1 (s_lvl0_rd and !reg_wr) |=> (reg_rdata == st_r.lvl[0]))
    else $error("level register readback mismatch");

  lowest_wins_a: assert property (
    (src_req[0] && src_req[1] && (st_r.lvl[0][1:0] == LVL_P2)
     && (st_r.lvl[0][3:2] == LVL_P2) && (core_mask < RANK_P2))
    |=> (irq_req && (irq_vec == VEC_W'(1))))
    else $error("lower vector did not win");

  raise_req_a: assert property (
    (win_found && (win_rank > core_mask)) |=> (irq_req && (irq_vec == $past(win_vec))))
    else $error("pending request not raised");

  normal_addr_a: assert property (
    (irq_req && !irq_fast)
    |-> (irq_addr == $past(tbl_base) + PADDR_W'({irq_vec, 1'b0})))
    else $error("normal jump address wrong");

  fast_addr_a: assert property (
    (irq_fast && (irq_vec == $past(st_r.match_a)))
    |-> (irq_addr == {$past(st_r.fah_a), $past(st_r.fal_a)}))
    else $error("fast slot a address wrong");

  fast_level_a: assert property (
    irq_fast |-> (st_r.rank == RANK_P2)
      && ((irq_vec == $past(st_r.match_a)) || (irq_vec == $past(st_r.match_b))))
    else $error("fast request not level 2 or not matched");

  mask_gate_a: assert property (
    irq_req |-> (st_r.rank > $past(core_mask)))
    else $error("request forwarded at or below mask");

  disabled_quiet_a: assert property (
    ((st_r.lvl == '0) && !src_req[SWLP_IDX]) |=> !irq_req)
    else $error("disabled sources raised a request");

  swlp_rank_a: assert property (
    (irq_req && (irq_vec == VEC_W'(NUM_SRC))) |-> (st_r.rank == RANK_SWLP))
    else $error("software low source not at lowest rank");

  reset_base_a: assert property (
    $rose(rst_n) |-> (tbl_base == boot_addr) && (wdog_addr == boot_addr + WDOG_OFS))
    else $error("vector base not on reset addresses");

  table_span_a: assert property (
    (st_r.vector_base_reg == VBA_RST) |-> (tbl_base + TBL_LAST_OFS == BOOT_RST + TBL_LAST_OFS)
      && (tbl_base + PADDR_W'({VEC_W'(NUM_SRC), 1'b1}) == BOOT_RST + TBL_LAST_OFS))
    else $error("vector table span wrong");

  read_once_a: assert property (
    (!reg_rd) |=> (reg_rdata == '0))
    else $error("read data outside its cycle");

endmodule // pva_arbiter

// [verif/pva_core_model.sv]
// Core-side model: takes its interrupt mask and fetches the offered jump address
`timescale 1ns/10ps
module pva_core_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [pva_pkg::RANK_W-1:0] mask_cmd,
  input wire logic irq_req,
  input wire logic [pva_pkg::PADDR_W-1:0] irq_addr,
  output logic [pva_pkg::RANK_W-1:0] core_mask,
  output logic [pva_pkg::PADDR_W-1:0] fetch_addr
);
  import pva_pkg::*;
  // Mask follows the software setting one edge later; fetch while a request stands
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      core_mask <= RANK_NONE;
      fetch_addr <= '0;
    end
    else
    begin
      core_mask <= mask_cmd;
      if (irq_req)
      begin
        fetch_addr <= irq_addr;
      end
    end
  end
endmodule // pva_core_model

// [verif/prioritized_vector_interrupt_arbiter_tb_top.sv]
// Self-checking bench for the prioritized vector interrupt arbiter
`timescale 1ns/10ps
module prioritized_vector_interrupt_arbiter_tb_top;
  import pva_pkg::*;
  typedef struct {int a; int b; logic [2:0] m; int v;} pva_row_s;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_SRC-1:0] src_req = '0;
  logic [RANK_W-1:0] mask_cmd = '0;
  logic [RANK_W-1:0] core_mask;
  logic [RADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic irq_req, irq_fast;
  logic [VEC_W-1:0] irq_vec;
  logic [PADDR_W-1:0] irq_addr, boot_addr, wdog_addr, tbl_base, fetch_addr;
  logic [PADDR_W-1:0] boot48, wdog48, tbl48;
  int bad_count = 0;
  int tests_run = 0;
  // Sources: vec1,2,3,5 level 2; vec11 level 1; vec21 level 0; vec31 off; 127 = none
  pva_row_s rows[13] = '{'{4, 127, 0, 5}, '{4, 2, 0, 3}, '{10, 4, 0, 5}, '{10, 20, 0, 11},
    '{30, 127, 0, 0}, '{65, 127, 0, 66}, '{65, 127, 1, 0}, '{4, 127, 4, 0},
    '{4, 127, 3, 5}, '{20, 127, 2, 0}, '{20, 127, 1, 21}, '{20, 65, 0, 21}, '{0, 1, 0, 1}};

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design under test, second variant and core model
  always #5 clk_sys = ~clk_sys;

  pva_arbiter i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .src_req(src_req),
    .core_mask(core_mask), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_fast(irq_fast),
    .irq_vec(irq_vec), .irq_addr(irq_addr), .boot_addr(boot_addr), .wdog_addr(wdog_addr),
    .tbl_base(tbl_base));

  pva_arbiter #(.VARIANT_48K(1'b1)) i_dut48 (.clk_sys(clk_sys), .rst_n(rst_n),
    .src_req(src_req), .core_mask(core_mask), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .irq_req(), .irq_fast(), .irq_vec(),
    .irq_addr(), .boot_addr(boot48), .wdog_addr(wdog48), .tbl_base(tbl48));

  pva_core_model i_core (.clk_sys(clk_sys), .rst_n(rst_n), .mask_cmd(mask_cmd),
    .irq_req(irq_req), .irq_addr(irq_addr), .core_mask(core_mask), .fetch_addr(fetch_addr));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One-cycle register read, data checked in the following cycle
  task automatic rd(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Raise up to two sources with a core mask, wait for mask and arbitration
  task automatic apply(input int a, input int b, input logic [2:0] m);
    logic [NUM_SRC-1:0] r;
    r = '0;
    if (a < NUM_SRC) r[a] = 1'b1;
    if (b < NUM_SRC) r[b] = 1'b1;
    @(posedge clk_sys);
    src_req <= r;
    mask_cmd <= m;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    #300000;
    bad_count++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(boot_addr, 21'h000000);
    chk(wdog_addr, 21'h000002);
    chk(tbl_base, boot_addr);
    chk(boot48, 21'h002000);
    chk(wdog48, 21'h002002);
    chk(tbl48, 21'h002000);
    chk(irq_req, 1'b0);
    rd(OFS_MATCH_A, 16'h0000);
    // Level codes: vec1,2,3,5 at level 2, vec11 level 1, vec21 level 0
    // First level register written and read back with no gap between strobes
    @(posedge clk_sys);
    reg_addr <= OFS_LVL0;
    reg_wdata <= 16'h033F;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 16'h033F);
    wr(5'h01, 16'h0020);
    wr(5'h02, 16'h0100);
    wr(5'h08, 16'h000F);
    rd(5'h08, 16'h0003);
    rd(5'h11, 16'h0000);
    foreach (rows[i])
    begin
      apply(rows[i].a, rows[i].b, rows[i].m);
      chk(irq_vec, rows[i].v);
      chk(irq_req, rows[i].v != 0);
      chk(irq_fast, 1'b0);
      chk(irq_addr, rows[i].v * 2);
    end
    // Fast slot a on a level 2 source
    wr(OFS_MATCH_A, 16'h0005);
    wr(OFS_FAL_A, 16'h2345);
    wr(OFS_FAH_A, 16'h0001);
    apply(4, 127, 0);
    chk(irq_fast, 1'b1);
    chk(irq_addr, 21'h012345);
    apply(127, 127, 0);
    chk(fetch_addr, 21'h012345);
    // Slot b naming a level 1 source stays normal
    wr(OFS_MATCH_B, 16'h000B);
    apply(10, 127, 0);
    chk(irq_fast, 1'b0);
    chk(irq_addr, 21'h000016);
    wr(OFS_MATCH_B, 16'h0003);
    wr(OFS_FAL_B, 16'h0BCD);
    wr(OFS_FAH_B, 16'h001F);
    apply(2, 127, 0);
    chk(irq_addr, 21'h1F0BCD);
    // Both slots name vec3: slot a is used
    wr(OFS_MATCH_A, 16'h0003);
    apply(2, 127, 0);
    chk(irq_addr, 21'h012345);
    // Moved vector base
    wr(OFS_MATCH_A, 16'h0000);
    wr(OFS_VBA, 16'hFFFF);
    rd(OFS_VBA, 16'h3FFF);
    wr(OFS_VBA, 16'h0040);
    chk(tbl_base, 21'h002000);
    apply(4, 127, 0);
    chk(irq_addr, 21'h00200A);
    rd(OFS_STATUS, 16'hA005);
    // Reset in mid-run restores the reset image
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(irq_req, 1'b0);
    chk(tbl_base, 21'h000000);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    apply(30, 127, 0);
    chk(irq_req, 1'b0);
    finish_test();
  end
endmodule // prioritized_vector_interrupt_arbiter_tb_top
